// [src/fdr_serial_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module fdr_serial_regs #(
  parameter int unsigned BASE_CYC = fdr_pkg::TIMEOUT_BASE_CYC,
  parameter int unsigned STEP_CYC = fdr_pkg::TIMEOUT_STEP_CYC,
  parameter logic [7:0] SIGNATURE = 8'h5A, // Arbitrary value
  parameter logic [3:0] REVISION = 4'h0 // Arbitrary value
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic serialClockPin,
  input wire logic serialDataPinIn,
  output logic serialDataPinOut,
  output logic serialDataPinOeN,
  output fdr_pkg::fdr_cfg_s cfg,
  output logic [31:0] timeoutCycles
);
  import fdr_pkg::*;

  fdr_state_e state_q, state_d;
  logic sclPrev_q, sclPrev_d;
  logic sdaPrev_q, sdaPrev_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [1:0] phase_q, phase_d;
  logic isRead_q, isRead_d;
  logic [7:0] ptr_q, ptr_d;
  logic oeN_q, oeN_d;
  logic [31:0] timeout_q, timeout_d;
  fdr_wr_s wr;
  logic [7:0] rdData;
  logic sclRise, sclFall, startCond, stopCond;

  // Pointer advance, wraps at 8 bits
  function automatic logic [7:0] ptrNext(input logic [7:0] p);
    return p + 8'h01;
  endfunction : ptrNext

  ////////////////////////////////////////////////////////////////////////////
  // Register bank
  fdr_regs #(
    .SIGNATURE(SIGNATURE),
    .REVISION(REVISION)
  ) uRegs (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr(wr),
    .rdAddr(ptr_q),
    .rdData(rdData),
    .cfg(cfg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus conditions
  assign sclRise = serialClockPin && !sclPrev_q;
  assign sclFall = !serialClockPin && sclPrev_q;
  assign startCond = serialClockPin && sclPrev_q
    && sdaPrev_q && !serialDataPinIn;
  assign stopCond = serialClockPin && sclPrev_q
    && !sdaPrev_q && serialDataPinIn;

  ////////////////////////////////////////////////////////////////////////////
  // Slave state machine
  always_comb begin
    state_d = state_q;
    sclPrev_d = serialClockPin;
    sdaPrev_d = serialDataPinIn;
    cnt_d = cnt_q;
    shift_d = shift_q;
    phase_d = phase_q;
    isRead_d = isRead_q;
    ptr_d = ptr_q;
    oeN_d = oeN_q;
    wr = '0;
    if (startCond) begin
      state_d = ST_RX;
      cnt_d = 4'h0;
      phase_d = PH_ADDR;
      oeN_d = 1'b1;
    end else if (stopCond) begin
      state_d = ST_IDLE;
      oeN_d = 1'b1;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          oeN_d = 1'b1;
        end
        ST_RX: begin
          if (sclRise && cnt_q != 4'h8) begin
            shift_d = {shift_q[6:0], serialDataPinIn};
            cnt_d = cnt_q + 4'h1;
          end else if (sclFall && cnt_q == 4'h8) begin
            state_d = ST_ACK;
            oeN_d = 1'b0;
            unique case (phase_q)
              PH_ADDR: begin
                if (shift_q[7:1] == SLAVE_ADDR) begin
                  isRead_d = shift_q[0];
                  phase_d = shift_q[0] ? PH_DATA : PH_PTR;
                end else begin
                  state_d = ST_IDLE;
                  oeN_d = 1'b1;
                end
              end
              PH_PTR: begin
                ptr_d = shift_q;
                phase_d = PH_DATA;
              end
              default: begin
                wr.en = 1'b1;
                wr.addr = ptr_q;
                wr.data = shift_q;
                ptr_d = ptrNext(ptr_q);
              end
            endcase
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            cnt_d = 4'h0;
            if (isRead_q) begin
              state_d = ST_TX;
              shift_d = rdData;
              oeN_d = rdData[7];
            end else begin
              state_d = ST_RX;
              oeN_d = 1'b1;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (cnt_q == 4'h7) begin
              state_d = ST_TXACK;
              oeN_d = 1'b1;
              ptr_d = ptrNext(ptr_q);
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              oeN_d = shift_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (sclRise) begin
            shift_d[0] = serialDataPinIn;
          end else if (sclFall) begin
            cnt_d = 4'h0;
            if (!shift_q[0]) begin
              state_d = ST_TX;
              shift_d = rdData;
              oeN_d = rdData[7];
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
          oeN_d = 1'b1;
        end
      endcase
    end
    timeout_d = BASE_CYC + STEP_CYC * 32'(cfg.flashTimeout);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      phase_q <= PH_ADDR;
      isRead_q <= 1'b0;
      ptr_q <= 8'h00;
      oeN_q <= 1'b1;
      timeout_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      sclPrev_q <= sclPrev_d;
      sdaPrev_q <= sdaPrev_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      phase_q <= phase_d;
      isRead_q <= isRead_d;
      ptr_q <= ptr_d;
      oeN_q <= oeN_d;
      timeout_q <= timeout_d;
    end
  end

  assign serialDataPinOut = 1'b0;
  assign serialDataPinOeN = oeN_q;
  assign timeoutCycles = timeout_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_ptr_increment: assert property (@(posedge mclk) disable iff (!rst_n)
    wr.en |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not increment after write");
  a_ack_drives_low: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == ST_ACK |-> !serialDataPinOeN)
    else $error("acknowledge not driven");
  a_addr_match: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == ST_RX && phase_q == PH_ADDR && !startCond && !stopCond
      && sclFall && cnt_q == 4'h8 && shift_q[7:1] != SLAVE_ADDR
      |=> state_q == ST_IDLE && serialDataPinOeN)
    else $error("foreign address acknowledged");
  a_read_keeps_ptr: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == ST_ACK && isRead_q && sclFall && !startCond && !stopCond
      |=> state_q == ST_TX && ptr_q == $past(ptr_q))
    else $error("read start moved pointer");
  a_timer_cycles: assert property (@(posedge mclk) disable iff (!rst_n)
    $stable(cfg.flashTimeout) |=> timeoutCycles
      == BASE_CYC + STEP_CYC * 32'($past(cfg.flashTimeout)))
    else $error("flash timer count wrong");
  a_nack_release: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == ST_TXACK |-> serialDataPinOeN)
    else $error("data held during master acknowledge");
  a_stop_release: assert property (@(posedge mclk) disable iff (!rst_n)
    stopCond |=> state_q == ST_IDLE && serialDataPinOeN)
    else $error("stop did not end the transfer");

endmodule : fdr_serial_regs
`default_nettype wire

// [src/fdr_pkg.sv]
// Overview of operation
// - Address 0 reads a fixed 8-bit identification byte; writes ignored.
// - Address 1 bits 3:0 read a fixed 4-bit silicon revision number.
// - Address 1 bits 7:4 are reserved, read-only; host must not use them.
// - Address 2 bits 3:0 select flash timer 100 ms plus 50 ms per step.
// - Address 2 bits 5:4 select the single/dual LED detection threshold.
// - Address 2 bits 7:6 select indicator LED current, 2.5 mA to 10 mA.
// - Address 2 holds all three fields, each readable and writable by host.
// - Serial slave at address 0110000; pointer advances per data byte.
// - A read without pointer write starts at the pointer's last held address.
package fdr_pkg;

  // Register map
  localparam logic [7:0] REG_ID = 8'h00;
  localparam logic [7:0] REG_REV = 8'h01;
  localparam logic [7:0] REG_TIMER = 8'h02;

  // Field positions and reset values
  localparam int REV_LSB = 0;
  localparam int REV_MSB = 3;
  localparam int RSV_LSB = 4;
  localparam int RSV_MSB = 7;
  localparam logic [3:0] RSV_VALUE = 4'h0;
  localparam logic [3:0] TIMEOUT_RST = 4'hF;
  localparam logic [1:0] THRESH_RST = 2'h0;
  localparam logic [1:0] IND_RST = 2'h0;

  // Serial slave address, 7 bits
  localparam logic [6:0] SLAVE_ADDR = 7'h30;

  // Timing
  localparam int unsigned MCLK_HZ = 40_000_000;
  localparam int unsigned TIMEOUT_BASE_MS = 100;
  localparam int unsigned TIMEOUT_STEP_MS = 50;
  localparam int unsigned TIMEOUT_BASE_CYC = TIMEOUT_BASE_MS * (MCLK_HZ / 1000);
  localparam int unsigned TIMEOUT_STEP_CYC = TIMEOUT_STEP_MS * (MCLK_HZ / 1000);

  // Byte phases within a transfer
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_PTR = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_TXACK = 3'b100
  } fdr_state_e;

  // Register 2 layout
  typedef struct packed {
    logic [1:0] indicatorCurrent;
    logic [1:0] ledCountThreshold;
    logic [3:0] flashTimeout;
  } fdr_cfg_s;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } fdr_wr_s;

endpackage : fdr_pkg

// [src/fdr_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module fdr_regs #(
  parameter logic [7:0] SIGNATURE = 8'h5A, // Arbitrary value
  parameter logic [3:0] REVISION = 4'h0 // Arbitrary value
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire fdr_pkg::fdr_wr_s wr,
  input wire logic [7:0] rdAddr,
  output logic [7:0] rdData,
  output fdr_pkg::fdr_cfg_s cfg
);
  import fdr_pkg::*;

  fdr_cfg_s cfg_q, cfg_d;
  logic [7:0] rdData_q, rdData_d;

  ////////////////////////////////////////////////////////////////////////////
  // Write and read decode
  always_comb begin
    cfg_d = cfg_q;
    if (wr.en && wr.addr == REG_TIMER) begin
      cfg_d = fdr_cfg_s'(wr.data);
    end
    unique case (rdAddr)
      REG_ID: rdData_d = SIGNATURE;
      REG_REV: rdData_d = {RSV_VALUE, REVISION};
      REG_TIMER: rdData_d = cfg_q;
      default: rdData_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= {IND_RST, THRESH_RST, TIMEOUT_RST};
      rdData_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      rdData_q <= rdData_d;
    end
  end

  assign cfg = cfg_q;
  assign rdData = rdData_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_id_constant: assert property (@(posedge mclk) disable iff (!rst_n)
    rdAddr == REG_ID |=> rdData == SIGNATURE)
    else $error("identification byte wrong");
  a_rev_field: assert property (@(posedge mclk) disable iff (!rst_n)
    rdAddr == REG_REV |=> rdData[REV_MSB:REV_LSB] == REVISION)
    else $error("revision field wrong");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    rdAddr == REG_REV |=> rdData[RSV_MSB:RSV_LSB] == RSV_VALUE)
    else $error("reserved bits not zero");
  a_timeout_write: assert property (@(posedge mclk) disable iff (!rst_n)
    wr.en && wr.addr == REG_TIMER |=> cfg.flashTimeout == $past(wr.data[3:0]))
    else $error("timeout field not written");
  a_thresh_write: assert property (@(posedge mclk) disable iff (!rst_n)
    wr.en && wr.addr == REG_TIMER
      |=> cfg.ledCountThreshold == $past(wr.data[5:4]))
    else $error("threshold field not written");
  a_ind_write: assert property (@(posedge mclk) disable iff (!rst_n)
    wr.en && wr.addr == REG_TIMER
      |=> cfg.indicatorCurrent == $past(wr.data[7:6]))
    else $error("indicator field not written");
  a_timer_readback: assert property (@(posedge mclk) disable iff (!rst_n)
    rdAddr == REG_TIMER |=> rdData == $past(cfg))
    else $error("timer register readback wrong");
  a_ro_unchanged: assert property (@(posedge mclk) disable iff (!rst_n)
    wr.en && wr.addr != REG_TIMER |=> $stable(cfg))
    else $error("read-only write changed state");

endmodule : fdr_regs
`default_nettype wire

// [tb/fdr_bus_master.sv]
`timescale 1ns/1ps
`default_nettype none
module fdr_bus_master (
  input wire logic mclk,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaDrv
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  //////////////////////////////////////////////////
  task automatic waitClk(input int n);
    repeat (n) @(posedge mclk);
  endtask : waitClk
  // One bit slot; data moves only while the clock is low
  task automatic clkBit(input logic b, output logic r);
    waitClk(2);
    sdaDrv <= b;
    waitClk(2);
    scl <= 1'b1;
    waitClk(3);
    r = sdaLine;
    waitClk(1);
    scl <= 1'b0;
  endtask : clkBit
  // Also serves as repeated start
  task automatic startCond();
    waitClk(2);
    sdaDrv <= 1'b1;
    waitClk(2);
    scl <= 1'b1;
    waitClk(3);
    sdaDrv <= 1'b0;
    waitClk(3);
    scl <= 1'b0;
  endtask : startCond
  task automatic stopCond();
    waitClk(2);
    sdaDrv <= 1'b0;
    waitClk(2);
    scl <= 1'b1;
    waitClk(3);
    sdaDrv <= 1'b1;
    waitClk(3);
  endtask : stopCond
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ackOut,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      clkBit(tx[i], rx[i]);
    end
    clkBit(ackOut, ack);
  endtask : xfer
endmodule : fdr_bus_master
`default_nettype wire

// [tb/flash_driver_id_timer_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_driver_id_timer_regs_test;
  import fdr_pkg::*;
  localparam int unsigned BASE = 100;
  localparam int unsigned STEP = 50;
  localparam logic [7:0] SIG = 8'hA7; // Arbitrary value
  localparam logic [3:0] REV = 4'h6; // Arbitrary value
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sdaDrv, sdaOut, sdaOeN, sdaLine, ack;
  logic [7:0] rx;
  fdr_cfg_s cfg;
  logic [31:0] tmo;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Open-drain line with pull-up
  assign sdaLine = sdaDrv & (sdaOeN | sdaOut);
  always #12.5 mclk = ~mclk;
  fdr_serial_regs #(
    .BASE_CYC(BASE),
    .STEP_CYC(STEP),
    .SIGNATURE(SIG),
    .REVISION(REV)
  ) dut (
    .mclk(mclk),
    .rst_n(rst_n),
    .serialClockPin(scl),
    .serialDataPinIn(sdaLine),
    .serialDataPinOut(sdaOut),
    .serialDataPinOeN(sdaOeN),
    .cfg(cfg),
    .timeoutCycles(tmo)
  );
  fdr_bus_master master (
    .mclk(mclk),
    .sdaLine(sdaLine),
    .scl(scl),
    .sdaDrv(sdaDrv)
  );
  //////////////////////////////////////////////////
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chk32(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk32
  task automatic chkBit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chkBit
  task automatic sendByte(input logic [7:0] d);
    master.xfer(d, 1'b1, rx, ack);
    chkBit("write ack", 1'b0, ack);
  endtask : sendByte
  task automatic openWrite(input logic [7:0] ptr);
    master.startCond();
    sendByte(8'h60);
    sendByte(ptr);
  endtask : openWrite
  task automatic openRead();
    master.startCond();
    sendByte(8'h61);
  endtask : openRead
  task automatic readByte(input logic last, input string what,
                          input logic [7:0] exp, input logic [7:0] mask);
    master.xfer(8'hFF, last, rx, ack);
    chk8(what, exp & mask, rx & mask);
  endtask : readByte
  //////////////////////////////////////////////////
  task automatic testReset();
    chk8("cfg at reset", 8'h0F, cfg);
    chk32("timeout at reset", BASE + 15 * STEP, tmo);
    openRead();
    readByte(1'b0, "id", SIG, 8'hFF);
    readByte(1'b0, "revision", {4'h0, REV}, 8'h0F);
    readByte(1'b1, "timer reg", 8'h0F, 8'hFF);
    master.stopCond();
    $display("Test reset done");
  endtask : testReset
  task automatic testFields();
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      v = 8'h55 * k[7:0];
      openWrite(8'h02);
      sendByte(v);
      master.stopCond();
      chk8("cfg", v, cfg);
      chk32("timeout", BASE + STEP * v[3:0], tmo);
      openWrite(8'h02);
      openRead();
      readByte(1'b1, "readback", v, 8'hFF);
      master.stopCond();
    end
    $display("Test fields done");
  endtask : testFields
  task automatic testReadOnly();
    openWrite(8'h00);
    sendByte(~SIG);
    sendByte(8'hFF);
    sendByte(8'h3C);
    master.stopCond();
    chk8("cfg after burst", 8'h3C, cfg);
    openWrite(8'h00);
    openRead();
    readByte(1'b0, "id kept", SIG, 8'hFF);
    readByte(1'b1, "revision kept", {4'h0, REV}, 8'h0F);
    master.stopCond();
    openWrite(8'h01);
    master.stopCond();
    openRead();
    readByte(1'b1, "read at pointer", {4'h0, REV}, 8'h0F);
    master.stopCond();
    $display("Test read-only done");
  endtask : testReadOnly
  task automatic testWrongAddr();
    master.startCond();
    master.xfer(8'h62, 1'b1, rx, ack);
    chkBit("foreign address ack", 1'b1, ack);
    master.xfer(8'h02, 1'b1, rx, ack);
    chkBit("ignored byte ack", 1'b1, ack);
    master.stopCond();
    chk8("cfg untouched", 8'h3C, cfg);
    $display("Test wrong address done");
  endtask : testWrongAddr
  //////////////////////////////////////////////////
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    testReset();
    testFields();
    testReadOnly();
    testWrongAddr();
    finish_test();
  end
endmodule : flash_driver_id_timer_regs_test
`default_nettype wire
